// >>> logic/ccasf_defines.svh
`ifndef CCASF_DEFINES_SVH
`define CCASF_DEFINES_SVH
// ==========================================
// status flag positions
`define CCASF_FI 7
`define CCASF_FT 6
`define CCASF_FH 5
`define CCASF_FS 4
`define CCASF_FV 3
`define CCASF_FN 2
`define CCASF_FZ 1
`define CCASF_FC 0
// ==========================================
// reset values and memory map
`define CCASF_STAT_RST 8'h00
`define CCASF_SP_RST 16'h0FFF
`define CCASF_BOOT_START 16'h7000
`define CCASF_VEC_FIRST 16'h0001
`define CCASF_IO_BASE 16'h0020
`define CCASF_IO_LAST 16'h005F
`define CCASF_XIO_FIRST 16'h0060
`define CCASF_XIO_LAST 16'h00FF
`define CCASF_IO_SPL 6'h1D
`define CCASF_IO_SPH 6'h1E
`define CCASF_IO_STAT 6'h1F
// ==========================================
// pointer pairs, low byte register
`define CCASF_PX 5'h1A
`define CCASF_PY 5'h1C
`define CCASF_PZ 5'h1E
// ==========================================
// software port offsets
`define CCASF_REG_STAT 4'h0
`define CCASF_REG_SP 4'h1
`define CCASF_REG_PC 4'h2
`endif

// >>> logic/ccasf_pkg.sv
package ccasf_pkg;
	typedef enum logic [2:0] {
		ST_EXEC = 3'h0,
		ST_WORD2 = 3'h1,
		ST_PUSH2 = 3'h3,
		ST_LDW1 = 3'h2,
		ST_LDW2 = 3'h6,
		ST_POPA = 3'h7,
		ST_POPB = 3'h5,
		ST_POPC = 3'h4
	} ccasf_state_t;
	typedef enum logic [3:0] {
		AL_ADD, AL_SUB, AL_AND, AL_EOR, AL_ADC, AL_SBC, AL_OR, AL_MOV,
		AL_COM, AL_NEG, AL_INC, AL_DEC, AL_LSR, AL_ROR, AL_SWAP
	} ccasf_aluop_t;
	typedef struct packed {
		logic [7:0] res;
		logic h, v, c, upH, upV, upC, upNZ;
	} ccasf_alu_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wd;
		logic we;
		logic re;
	} ccasf_dbus_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wd;
		logic we;
	} ccasf_spm_t;
	typedef struct packed {
		ccasf_state_t st;
		logic valid;
		logic [15:0] fetch, ia, savePc, tgt, word1;
		logic [4:0] ldReg;
		logic isLpm;
		logic [7:0] hiByte, stat;
		logic [15:0] sp;
		logic [31:0][7:0] rf;
		ccasf_dbus_t bus;
		ccasf_spm_t self_program_write_instr;
		logic ack;
		logic [2:0] ackIdx;
		logic [15:0] rd;
		logic aluUpd;
		logic [7:0] aluRes;
	} ccasf_core_t;
endpackage

// >>> logic/ccasf_core.sv
`timescale 1ns/1ps
`include "ccasf_defines.svh"
// Overview of operation
// RULE1: fetch next word while current one executes
// RULE2: 32x8 register file, read-operate-write one cycle
// RULE3: three register pairs form 16-bit pointers
// RULE4: register, constant and single-register ALU ops
// RULE5: every ALU operation updates status flags; MOV and SWAP leave them unchanged
// RULE6: interrupts never save or restore status
// RULE7: decoder handles one- and two-word instructions
// RULE8: application writes only from boot section; the code also allows them when pointer Z is inside the boot section
// RULE9: calls and interrupts push return address
// RULE10: lower vector wins among pending interrupts
// RULE11: I/O space also at data 0x20-0x5F
// RULE12: extended I/O only by load/store
// RULE13: bit 7 gates every interrupt
// RULE14: taking clears enable; return and instructions set
// RULE15: bit 6 is bit copy store
// RULE16: bit 5 holds low nibble carry
// RULE17: bit 4 always negative xor overflow
// RULE18: bit 3 holds two's complement overflow
// RULE19: bit 2 shows negative result
// RULE20: bit 1 shows zero result
// RULE21: bit 0 holds carry
// RULE22: negative is result msb, zero all-bits clear
// RULE23: reset clears all status flags
module ccasf_core (
	input logic clk,
	input logic rst_n,
	output logic [15:0] progAddr,
	input logic [15:0] progData,
	output ccasf_pkg::ccasf_dbus_t dbus,
	input logic [7:0] dataRdData,
	output ccasf_pkg::ccasf_spm_t self_program_write_instr,
	input logic [7:0] irqReq,
	output logic irqAck,
	output logic [2:0] irqAckIdx,
	input logic [3:0] regAddr,
	input logic [15:0] regWrData,
	input logic regWr,
	input logic regRd,
	output logic [15:0] regRdData
);
	ccasf_pkg::ccasf_core_t q, n;
	ccasf_pkg::ccasf_alu_t al;
	ccasf_pkg::ccasf_aluop_t aluOp;
	logic [15:0] ins, nextPc, rtgt, mAddr, ioOff, pX, pY, pZ, ptr;
	logic [15:0] pRet, pTgt;
	logic [7:0] rdv, rrv, aluA, aluB;
	logic [4:0] d5, r5, dI, aluDst, mReg;
	logic [2:0] irqSel;
	logic redir, doAlu, mLd, mSt, intHit, push;

	// ==========================================
	// alu
	function automatic ccasf_pkg::ccasf_alu_t alu(
		input ccasf_pkg::ccasf_aluop_t op,
		input logic [7:0] a,
		input logic [7:0] b,
		input logic cin);
		ccasf_pkg::ccasf_alu_t o;
		logic [8:0] s;
		logic [4:0] hs;
		logic ci;
		o = '0;
		s = '0;
		hs = '0;
		ci = 1'b0;
		o.upNZ = 1'b1;
		case (op)
			ccasf_pkg::AL_ADD, ccasf_pkg::AL_ADC: begin
				ci = (op == ccasf_pkg::AL_ADC) & cin;
				s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
				hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
				o.v = (a[7] == b[7]) && (s[7] != a[7]); // RULE18
				{o.upH, o.upV, o.upC} = 3'h7;
			end
			ccasf_pkg::AL_SUB, ccasf_pkg::AL_SBC, ccasf_pkg::AL_NEG: begin
				ci = (op == ccasf_pkg::AL_SBC) & cin;
				s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
				hs = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
				o.v = (a[7] != b[7]) && (s[7] != a[7]); // RULE18
				{o.upH, o.upV, o.upC} = 3'h7;
			end
			ccasf_pkg::AL_AND: begin
				s = {1'b0, a & b};
				o.upV = 1'b1;
			end
			ccasf_pkg::AL_OR: begin
				s = {1'b0, a | b};
				o.upV = 1'b1;
			end
			ccasf_pkg::AL_EOR: begin
				s = {1'b0, a ^ b};
				o.upV = 1'b1;
			end
			ccasf_pkg::AL_COM: begin
				s = {1'b1, ~a};
				{o.upV, o.upC} = 2'h3;
			end
			ccasf_pkg::AL_INC: begin
				s = {1'b0, a + 8'h01};
				o.v = (a == 8'h7F);
				o.upV = 1'b1;
			end
			ccasf_pkg::AL_DEC: begin
				s = {1'b0, a - 8'h01};
				o.v = (a == 8'h80);
				o.upV = 1'b1;
			end
			ccasf_pkg::AL_LSR: begin
				s = {a[0], 1'b0, a[7:1]};
				o.v = a[0];
				{o.upV, o.upC} = 2'h3;
			end
			ccasf_pkg::AL_ROR: begin
				s = {a[0], cin, a[7:1]};
				o.v = cin ^ a[0];
				{o.upV, o.upC} = 2'h3;
			end
			ccasf_pkg::AL_SWAP: begin
				s = {1'b0, a[3:0], a[7:4]};
				o.upNZ = 1'b0;
			end
			default: begin
				s = {1'b0, b};
				o.upNZ = 1'b0;
			end
		endcase
		o.res = s[7:0];
		o.c = s[8]; // RULE21
		o.h = hs[4]; // RULE16
		return o;
	endfunction

	// ==========================================
	// next state
	always_comb begin
		n = q;
		ins = progData;
		d5 = ins[4:0];
		r5 = ins[9:5];
		dI = {1'b1, ins[11:8]};
		rdv = q.rf[d5];
		rrv = q.rf[r5];
		pX = {q.rf[`CCASF_PX + 5'h01], q.rf[`CCASF_PX]}; // RULE3
		pY = {q.rf[`CCASF_PY + 5'h01], q.rf[`CCASF_PY]};
		pZ = {q.rf[`CCASF_PZ + 5'h01], q.rf[`CCASF_PZ]};
		ptr = ins[10] ? pZ : (ins[9] ? pY : pX);
		nextPc = q.ia + 16'h0001;
		n.bus.we = 1'b0;
		n.bus.re = 1'b0;
		n.self_program_write_instr.we = 1'b0;
		n.ack = 1'b0;
		n.aluUpd = 1'b0;
		n.rd = 16'h0000;
		n.fetch = q.fetch + 16'h0001; // RULE1
		n.valid = 1'b1;
		n.ia = q.fetch;
		{redir, doAlu, mLd, mSt, push, intHit} = 6'h00;
		rtgt = 16'h0000;
		pRet = 16'h0000;
		pTgt = 16'h0000;
		aluOp = ccasf_pkg::AL_MOV;
		aluA = rdv;
		aluB = rrv;
		aluDst = d5;
		mAddr = 16'h0000;
		mReg = d5;
		ioOff = 16'h0000;
		irqSel = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (irqReq[i])
				irqSel = i[2:0]; // RULE10
		end
		// core updates below override a software write in the same cycle
		if (regWr) begin
			case (regAddr)
				`CCASF_REG_STAT: n.stat = regWrData[7:0];
				`CCASF_REG_SP: n.sp = regWrData;
				default: ;
			endcase
		end
		if (regRd) begin
			case (regAddr)
				`CCASF_REG_STAT: n.rd = {8'h00, q.stat};
				`CCASF_REG_SP: n.rd = q.sp;
				`CCASF_REG_PC: n.rd = q.ia;
				default: n.rd = 16'h0000;
			endcase
		end
		case (q.st)
			ccasf_pkg::ST_EXEC: if (q.valid) begin
				if (q.stat[`CCASF_FI] && (|irqReq)) begin // RULE13
					// status not saved on entry, only the enable bit cleared
					push = 1'b1; // RULE6
					pRet = q.ia;
					pTgt = `CCASF_VEC_FIRST + {13'h0000, irqSel};
					n.stat[`CCASF_FI] = 1'b0; // RULE14
					n.ack = 1'b1;
					n.ackIdx = irqSel;
				end else begin
					case (ins[15:12])
						4'h0, 4'h1: begin
							doAlu = 1'b1; // RULE4
							aluOp = ccasf_pkg::ccasf_aluop_t'({1'b0, ins[12],
								ins[11:10]});
						end
						4'h2, 4'h3, 4'h4: begin
							doAlu = 1'b1; // RULE4
							aluDst = dI;
							aluA = q.rf[dI];
							aluB = ins[7:0];
							aluOp = ins[14] ? ccasf_pkg::AL_AND :
								(ins[12] ? ccasf_pkg::AL_SUB : ccasf_pkg::AL_MOV);
						end
						4'h5: begin
							case (ins[11:8])
								4'h7: n.stat[`CCASF_FT] = rdv[ins[7:5]]; // RULE15
								4'h8: n.rf[d5][ins[7:5]] = q.stat[`CCASF_FT]; // RULE15
								4'h9: n.stat[`CCASF_FI] = 1'b1; // RULE14
								4'hA: n.stat[`CCASF_FI] = 1'b0; // RULE14
								4'hB, 4'hC: begin
									if (ins[8] == 1'b0)
										n.stat[`CCASF_FI] = 1'b1; // RULE14
									n.bus.addr = q.sp + 16'h0001;
									n.bus.re = 1'b1;
									n.sp = q.sp + 16'h0001;
									n.st = ccasf_pkg::ST_POPA;
								end
								4'hD: begin
									// table read from program memory at pointer three
									redir = 1'b1; // RULE3
									rtgt = {1'b0, pZ[15:1]};
									n.tgt = pZ;
									n.isLpm = 1'b1;
									n.ldReg = d5;
									n.savePc = nextPc;
									n.st = ccasf_pkg::ST_LDW1;
								end
								default: if (ins[11] == 1'b0) begin
									doAlu = 1'b1; // RULE4
									aluOp = ccasf_pkg::ccasf_aluop_t'({1'b1,
										ins[10:8]});
									aluA = (ins[10:8] == 3'h1) ? 8'h00 : rdv;
									aluB = rdv;
								end
							endcase
						end
						4'h6: begin
							mAddr = ptr; // RULE3
							mSt = ins[11];
							mLd = ~ins[11];
						end
						4'h7: begin
							// six-bit field cannot reach extended I/O
							mAddr = `CCASF_IO_BASE + {10'h000, ins[10:5]}; // RULE12
							mSt = ins[11];
							mLd = ~ins[11];
						end
						4'h8, 4'hC: begin
							n.st = ccasf_pkg::ST_WORD2; // RULE7
							n.word1 = ins;
						end
						4'h9: begin
							redir = 1'b1;
							rtgt = nextPc + {{4{ins[11]}}, ins[11:0]};
						end
						4'hA: begin
							push = 1'b1; // RULE9
							pRet = nextPc;
							pTgt = nextPc + {{4{ins[11]}}, ins[11:0]};
						end
						4'hB: if (q.stat[ins[10:8]] == ins[11]) begin // RULE5
							redir = 1'b1;
							rtgt = nextPc + {{8{ins[7]}}, ins[7:0]};
						end
						4'hD: begin
							n.self_program_write_instr.addr = pZ;
							n.self_program_write_instr.wd = {q.rf[5'h01], q.rf[5'h00]};
							n.self_program_write_instr.we = (q.ia >= `CCASF_BOOT_START) ||
								(pZ >= `CCASF_BOOT_START); // RULE8
						end
						default: ;
					endcase
				end
			end
			ccasf_pkg::ST_WORD2: begin
				n.st = ccasf_pkg::ST_EXEC;
				if (q.word1[15:12] == 4'hC) begin
					redir = 1'b1; // RULE7
					rtgt = ins;
				end else begin
					mAddr = ins; // RULE7
					mReg = q.word1[4:0];
					mSt = q.word1[11];
					mLd = ~q.word1[11];
				end
			end
			ccasf_pkg::ST_PUSH2: begin
				n.bus.addr = q.sp;
				n.bus.wd = q.savePc[15:8];
				n.bus.we = 1'b1; // RULE9
				n.sp = q.sp - 16'h0001;
				redir = 1'b1;
				rtgt = q.tgt;
				n.st = ccasf_pkg::ST_EXEC;
			end
			ccasf_pkg::ST_LDW1: begin
				n.fetch = q.fetch;
				n.valid = 1'b0;
				n.st = ccasf_pkg::ST_LDW2;
			end
			ccasf_pkg::ST_LDW2: begin
				if (q.isLpm)
					n.rf[q.ldReg] = q.tgt[0] ? progData[15:8] : progData[7:0];
				else
					n.rf[q.ldReg] = dataRdData;
				redir = 1'b1;
				rtgt = q.savePc;
				n.st = ccasf_pkg::ST_EXEC;
			end
			ccasf_pkg::ST_POPA: begin
				n.fetch = q.fetch;
				n.valid = 1'b0;
				n.bus.addr = q.sp + 16'h0001;
				n.bus.re = 1'b1;
				n.sp = q.sp + 16'h0001;
				n.st = ccasf_pkg::ST_POPB;
			end
			ccasf_pkg::ST_POPB: begin
				n.fetch = q.fetch;
				n.valid = 1'b0;
				n.hiByte = dataRdData;
				n.st = ccasf_pkg::ST_POPC;
			end
			ccasf_pkg::ST_POPC: begin
				redir = 1'b1;
				rtgt = {q.hiByte, dataRdData};
				n.st = ccasf_pkg::ST_EXEC;
			end
			default: n.st = ccasf_pkg::ST_EXEC;
		endcase
		// internal I/O answers at once, the rest goes out on the data bus
		if (mLd | mSt) begin
			ioOff = mAddr - `CCASF_IO_BASE;
			intHit = (mAddr >= `CCASF_IO_BASE) && (mAddr <= `CCASF_IO_LAST) &&
				(ioOff[5:0] >= `CCASF_IO_SPL); // RULE11
			if (intHit && mSt) begin
				case (ioOff[5:0])
					`CCASF_IO_SPL: n.sp[7:0] = q.rf[mReg];
					`CCASF_IO_SPH: n.sp[15:8] = q.rf[mReg];
					default: n.stat = q.rf[mReg];
				endcase
			end else if (intHit) begin
				case (ioOff[5:0])
					`CCASF_IO_SPL: n.rf[mReg] = q.sp[7:0];
					`CCASF_IO_SPH: n.rf[mReg] = q.sp[15:8];
					default: n.rf[mReg] = q.stat;
				endcase
			end else begin
				n.bus.addr = mAddr; // RULE12
				n.bus.wd = q.rf[mReg];
				n.bus.we = mSt;
				n.bus.re = mLd;
				if (mLd) begin
					n.st = ccasf_pkg::ST_LDW1;
					n.isLpm = 1'b0;
					n.ldReg = mReg;
					n.savePc = nextPc;
				end
			end
		end
		if (push) begin
			n.bus.addr = q.sp;
			n.bus.wd = pRet[7:0];
			n.bus.we = 1'b1; // RULE9
			n.sp = q.sp - 16'h0001;
			n.savePc = pRet;
			n.tgt = pTgt;
			n.st = ccasf_pkg::ST_PUSH2;
		end
		al = alu(aluOp, aluA, aluB, q.stat[`CCASF_FC]);
		if (doAlu) begin
			n.rf[aluDst] = al.res; // RULE2
			if (al.upH)
				n.stat[`CCASF_FH] = al.h; // RULE16
			if (al.upV)
				n.stat[`CCASF_FV] = al.v; // RULE18
			if (al.upC)
				n.stat[`CCASF_FC] = al.c; // RULE21
			if (al.upNZ) begin
				n.stat[`CCASF_FN] = al.res[7]; // RULE19 RULE22
				n.stat[`CCASF_FZ] = (al.res == 8'h00); // RULE20 RULE22
			end
			n.aluUpd = al.upNZ; // RULE5
			n.aluRes = al.res;
		end
		// a taken branch costs one bubble while the new word arrives
		if (redir) begin
			n.fetch = rtgt; // RULE1
			n.valid = 1'b0;
		end
		n.stat[`CCASF_FS] = n.stat[`CCASF_FN] ^ n.stat[`CCASF_FV]; // RULE17
	end

	// ==========================================
	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.stat <= `CCASF_STAT_RST; // RULE23
			q.sp <= `CCASF_SP_RST;
		end else begin
			q <= n;
		end
	end

	assign progAddr = q.fetch;
	assign dbus = q.bus;
	assign self_program_write_instr = q.self_program_write_instr;
	assign irqAck = q.ack;
	assign irqAckIdx = q.ackIdx;
	assign regRdData = q.rd;

	// ==========================================
	// checks
	logic [7:0] lowMask;
	logic [15:0] vecAddr;
	assign lowMask = (8'h01 << q.ackIdx) - 8'h01;
	assign vecAddr = `CCASF_VEC_FIRST + {13'h0000, q.ackIdx};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_sign_flag: assert property ( // RULE17
		q.stat[`CCASF_FS] == (q.stat[`CCASF_FN] ^ q.stat[`CCASF_FV]))
		else $error("sign flag not n xor v");
	chk_fetch_ahead: assert property ( // RULE1
		q.valid |-> q.fetch == q.ia + 16'h0001)
		else $error("fetch not one word ahead");
	chk_fetch_restart: assert property ( // RULE1
		(q.st == ccasf_pkg::ST_EXEC && !q.valid) |=> q.valid)
		else $error("fetch bubble longer than one cycle");
	chk_irq_gate: assert property ( // RULE13
		q.ack |-> $past(q.stat[`CCASF_FI]))
		else $error("interrupt taken while disabled");
	chk_irq_clear: assert property ( // RULE14
		q.ack |-> !q.stat[`CCASF_FI])
		else $error("enable not cleared on entry");
	chk_irq_prio: assert property ( // RULE10
		q.ack |-> ($past(irqReq) & lowMask) == 8'h00)
		else $error("lower vector was pending");
	chk_irq_vector: assert property ( // RULE10
		q.ack |=> q.fetch == $past(vecAddr))
		else $error("wrong vector fetched");
	chk_push_pair: assert property ( // RULE9
		q.ack |-> q.bus.we ##1 (q.bus.we &&
			q.sp == $past(q.sp, 2) - 16'h0002))
		else $error("return address not pushed");
	chk_flag_nz: assert property ( // RULE22
		q.aluUpd |-> (q.stat[`CCASF_FZ] == (q.aluRes == 8'h00)) &&
			(q.stat[`CCASF_FN] == q.aluRes[7]))
		else $error("negative or zero flag wrong");
	chk_spm_guard: assert property ( // RULE8
		q.self_program_write_instr.we |-> (q.self_program_write_instr.addr >= `CCASF_BOOT_START) ||
			($past(q.ia) >= `CCASF_BOOT_START))
		else $error("application write from outside boot");
	chk_load_wait: assert property ( // RULE3
		q.st == ccasf_pkg::ST_LDW1 |=> q.st == ccasf_pkg::ST_LDW2
			##1 q.st == ccasf_pkg::ST_EXEC)
		else $error("load wait sequence broken");

	cov_irq: cover property (q.ack);
	cov_spm: cover property (q.self_program_write_instr.we);
	cov_ret: cover property (q.st == ccasf_pkg::ST_POPC);
	cov_load: cover property (q.st == ccasf_pkg::ST_LDW2 && !q.isLpm);
endmodule

// >>> sim/ccasf_core_tb.sv
`timescale 1ns/1ps
module ccasf_core_tb;
// ==========================================
// signals and memories
logic clk = 1'b0;
logic rst_n = 1'b0;
logic [15:0] progAddr;
logic [15:0] progData = 16'h0000;
ccasf_pkg::ccasf_dbus_t dbus;
logic [7:0] dataRdData = 8'h00;
ccasf_pkg::ccasf_spm_t self_program_write_instr;
logic [7:0] irqReq = 8'h00;
logic irqAck;
logic [2:0] irqAckIdx;
logic [3:0] regAddr = 4'h0;
logic [15:0] regWrData = 16'h0000;
logic regWr = 1'b0;
logic regRd = 1'b0;
logic [15:0] regRdData;
logic [15:0] pmem [0:255];
logic [7:0] dmem [0:4095];
int error_cnt = 0;
int compares = 0;
int ackCnt = 0;
int spmCnt = 0;
int n;
logic [15:0] rdv;
typedef logic [15:0] ccasf_img_t [16];
typedef struct {
	logic [15:0] op;
	logic [7:0] a, b, res, stat;
} ccasf_row_t;
// operand a in r16, b in r17, result stored at data 0x100
ccasf_row_t rows [11] = '{
	'{16'h0230, 8'h0F, 8'h01, 8'h10, 8'h20},
	'{16'h0230, 8'h80, 8'h80, 8'h00, 8'h1B},
	'{16'h0230, 8'h7F, 8'h01, 8'h80, 8'h2C},
	'{16'h0630, 8'h00, 8'h01, 8'hFF, 8'h35},
	'{16'h0630, 8'h80, 8'h01, 8'h7F, 8'h38},
	'{16'h0630, 8'h55, 8'h55, 8'h00, 8'h02},
	'{16'h0A30, 8'hF0, 8'h8F, 8'h80, 8'h14},
	'{16'h0E30, 8'hAA, 8'hAA, 8'h00, 8'h02},
	'{16'h1A30, 8'h0F, 8'h30, 8'h3F, 8'h00},
	'{16'h5210, 8'h7F, 8'h00, 8'h80, 8'h0C},
	'{16'h3010, 8'h10, 8'h00, 8'h00, 8'h02}
};
logic [15:0] swWr [4] = '{16'h0010, 16'h0008, 16'h000C, 16'hFFFF};
logic [15:0] swRd [4] = '{16'h0000, 16'h0018, 16'h000C, 16'h00EF};

always #20 clk = ~clk;

ccasf_core i_ccasf_core (
	.clk(clk),
	.rst_n(rst_n),
	.progAddr(progAddr),
	.progData(progData),
	.dbus(dbus),
	.dataRdData(dataRdData),
	.self_program_write_instr(self_program_write_instr),
	.irqReq(irqReq),
	.irqAck(irqAck),
	.irqAckIdx(irqAckIdx),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regWr(regWr),
	.regRd(regRd),
	.regRdData(regRdData)
);

// ==========================================
// memories behind the core
// read data stands only one cycle, so it is scrambled otherwise
always @(posedge clk) begin
	progData <= pmem[progAddr[7:0]];
	dataRdData <= dbus.re ? dmem[dbus.addr[11:0]] : ~dataRdData;
	if (dbus.we)
		dmem[dbus.addr[11:0]] <= dbus.wd;
	if (self_program_write_instr.we)
		spmCnt <= spmCnt + 1;
	if (irqAck)
		ackCnt <= ackCnt + 1;
end

// ==========================================
// tasks
task automatic chk16(input logic [15:0] g, input logic [15:0] e,
	input string s);
	compares++;
	if (g !== e) begin
		error_cnt++;
		$display("Error at %0t: %s got %h want %h", $time, s, g, e);
	end
endtask
task automatic chk8(input logic [7:0] g, input logic [7:0] e,
	input string s);
	compares++;
	if (g !== e) begin
		error_cnt++;
		$display("Error at %0t: %s got %h want %h", $time, s, g, e);
	end
endtask
task automatic chk1(input logic g, input logic e, input string s);
	compares++;
	if (g !== e) begin
		error_cnt++;
		$display("Error at %0t: %s got %b want %b", $time, s, g, e);
	end
endtask
task automatic cyc(input int c);
	repeat (c) @(posedge clk);
endtask
// image words beyond the first sixteen are no-ops
task automatic do_reset(input ccasf_img_t img, input int c);
	@(posedge clk);
	rst_n <= 1'b0;
	for (int i = 0; i < 256; i++)
		pmem[i] = (i < 16) ? img[i] : 16'hE000;
	cyc(c);
	rst_n <= 1'b1;
endtask
task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
	@(posedge clk);
	regAddr <= a;
	regWrData <= d;
	regWr <= 1'b1;
	@(posedge clk);
	regWr <= 1'b0;
endtask
task automatic rd_chk(input logic [3:0] a, input logic [15:0] e,
	input string s);
	@(posedge clk);
	regAddr <= a;
	regRd <= 1'b1;
	@(posedge clk);
	regRd <= 1'b0;
	#1 chk16(regRdData, e, s);
endtask
task automatic test_done(input string s);
	$display("test %s done", s);
endtask
task automatic stop_test();
	$display("compares %0d mismatches %0d", compares, error_cnt);
	if (error_cnt == 0 && compares > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask

// ==========================================
// watchdog, far above the few hundred cycles needed
initial begin
	#(40 * 5000);
	error_cnt++;
	$display("Error at %0t: watchdog expired", $time);
	stop_test();
end

// ==========================================
// tests
initial begin
	foreach (dmem[i])
		dmem[i] = 8'h00;
	do_reset('{default: 16'hE000}, 12);
	cyc(3);
	#1 chk16(progAddr, 16'h0003, "fetch step");
	rd_chk(4'h0, 16'h0000, "status reset");
	@(posedge clk);
	#1 chk16(regRdData, 16'h0000, "read hold");
	rd_chk(4'h1, 16'h0FFF, "stack reset");
	reg_wr(4'hF, 16'h00FF);
	rd_chk(4'hF, 16'h0000, "unmapped");
	reg_wr(4'h1, 16'h0123);
	rd_chk(4'h1, 16'h0123, "stack write");
	for (int i = 0; i < 4; i++) begin
		reg_wr(4'h0, swWr[i]);
		rd_chk(4'h0, swRd[i], "sign forced");
	end
	test_done("reset and port");
	foreach (rows[i]) begin
		dmem[256] = ~rows[i].res;
		do_reset('{0: 16'h2000 | rows[i].a, 1: 16'h2100 | rows[i].b,
			2: rows[i].op, 3: 16'h8810, 4: 16'h0100,
			default: 16'hE000}, 2);
		cyc(20);
		chk8(dmem[256], rows[i].res, "alu result");
		rd_chk(4'h0, {8'h00, rows[i].stat}, "alu flags");
	end
	test_done("alu rows");
	// out/in on status, store to its data alias, extended store, spm
	do_reset('{0: 16'h2008, 1: 16'h7BF0, 2: 16'h73F2, 3: 16'h8812,
		4: 16'h0101, 5: 16'h210C, 6: 16'h8811, 7: 16'h003F,
		8: 16'h8811, 9: 16'h0060, 10: 16'h2E10, 11: 16'h2F00,
		12: 16'hD000, 13: 16'h2F70, 14: 16'hD000,
		default: 16'hE000}, 2);
	cyc(30);
	chk8(dmem[257], 8'h18, "io path");
	rd_chk(4'h0, 16'h000C, "data alias");
	chk8(dmem[63], 8'h00, "alias on bus");
	chk8(dmem[96], 8'h0C, "extended io");
	chk16(16'(spmCnt), 16'h0001, "app write");
	chk16(self_program_write_instr.addr, 16'h7010, "write addr");
	test_done("io map");
	// set, read back, clear, then bit store and bit load
	do_reset('{0: 16'h5900, 1: 16'h73F3, 2: 16'h8813, 3: 16'h0103,
		4: 16'h5A00, 5: 16'h2008, 6: 16'h2100, 7: 16'h5770,
		8: 16'h5811, 9: 16'h8811, 10: 16'h0102,
		default: 16'hE000}, 2);
	cyc(30);
	chk8(dmem[259], 8'h80, "set enable");
	chk8(dmem[258], 8'h01, "bit load");
	rd_chk(4'h0, 16'h0040, "bit store");
	test_done("bit copy");
	// handler for vector 1, at address 2, changes flags, then returns
	do_reset('{0: 16'hC000, 1: 16'h0010, 2: 16'h0E10, 3: 16'h5C00,
		default: 16'hE000}, 2);
	cyc(5);
	irqReq <= 8'h06;
	cyc(10);
	chk16(16'(ackCnt), 16'h0000, "ack disabled");
	reg_wr(4'h0, 16'h0081);
	#1 n = 0;
	while (irqAck !== 1'b1 && n < 20) begin
		@(posedge clk);
		#1 n++;
	end
	chk1(irqAck, 1'b1, "ack seen");
	chk16(16'(irqAckIdx), 16'h0001, "priority");
	chk1(dbus.we, 1'b1, "push one");
	chk16(dbus.addr, 16'h0FFF, "push one addr");
	@(posedge clk);
	irqReq <= 8'h00;
	#1 chk1(dbus.we, 1'b1, "push two");
	chk16(dbus.addr, 16'h0FFE, "push two addr");
	n = 0;
	while (progAddr !== 16'h0002 && n < 4) begin
		@(posedge clk);
		#1 n++;
	end
	chk16(progAddr, 16'h0002, "vector fetch");
	cyc(20);
	rd_chk(4'h0, 16'h0083, "no restore");
	rd_chk(4'h1, 16'h0FFF, "stack back");
	chk16(16'(ackCnt), 16'h0001, "one taken");
	test_done("interrupt");
	stop_test();
end
endmodule
